// ### hw/abgd_pkg.sv
// bridge package: constants shared by the bridge and its write guard
// assumes 32-bit bus data, one bus clock and 1 KB of address per peripheral

package abgd_pkg;
    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned NPERIPH = 32; // peripherals behind one bridge

    // ------------------------------------------------------------
    // peripheral slot decode: haddr[14:10] picks the peripheral
    // ------------------------------------------------------------
    localparam int unsigned SLOT_LSB = 10;
    localparam int unsigned SLOT_W = 5;
    localparam logic [SLOT_W-1:0] GUARD_SLOT = 5'h00;

    // ------------------------------------------------------------
    // guard register offsets inside its slot (byte addresses)
    // ------------------------------------------------------------
    localparam logic [9:0] OFF_PROT_CLEAR = 10'h000;
    localparam logic [9:0] OFF_PROT_SET = 10'h004;
    localparam logic [31:0] PROT_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // upstream bus codes
    // ------------------------------------------------------------
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam int unsigned HTRANS_ACTIVE_BIT = 1; // nonseq or seq
    localparam logic [3:0] DEBUG_MASTER_ID = 4'h1; // debug unit

    // ------------------------------------------------------------
    // bridge states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_DATA   = 6'h02,
        ST_SETUP  = 6'h04,
        ST_ACCESS = 6'h08,
        ST_ERR1   = 6'h10,
        ST_ERR2   = 6'h20
    } abgd_state_e;
endpackage

// ### hw/abgd_guard.sv
// write guard: one protection bit per peripheral, set and clear views
// assumes the caller gives one write pulse per bus write and reads vec

`timescale 1ns/1ps

module abgd_guard
    import abgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic wr_set,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [NPERIPH-1:0] prot_vec,
    output logic wr_err
);

    logic [NPERIPH-1:0] prot_r;

    // ------------------------------------------------------------
    // double protect or double unprotect check
    // ------------------------------------------------------------
    // zero bits never raise an error [R17]
    assign wr_err = wr_set ? |(prot_r & wr_data) // [R14]
                           : |(~prot_r & wr_data); // [R15]
    assign prot_vec = prot_r; // same vector for both views [R12]

    // ------------------------------------------------------------
    // protection vector update, refused write leaves it as is
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prot_r <= PROT_RESET;
        end else if (ce && wr_en && !wr_err) begin
            if (wr_set) begin
                prot_r <= prot_r | wr_data; // [R11] [R17]
            end else begin
                prot_r <= prot_r & ~wr_data; // [R10] [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_set_applies: assert property (@(posedge ref_clk) // [R11]
        disable iff (!arst_n || !ce)
        wr_en && wr_set && !wr_err |=> (prot_r & $past(wr_data))
            == $past(wr_data))
        else $error("protect set bits not applied");

    chk_clear_applies: assert property (@(posedge ref_clk) // [R10]
        disable iff (!arst_n || !ce)
        wr_en && !wr_set && !wr_err |=> (prot_r & $past(wr_data)) == '0)
        else $error("protect clear bits not applied");

    chk_double_keeps: assert property (@(posedge ref_clk) // [R14]
        disable iff (!arst_n || !ce)
        wr_en && wr_err |=> $stable(prot_r))
        else $error("refused guard write changed the vector");
endmodule

// ### hw/abgd_bridge.sv
// bus bridge top: upstream bus slave, downstream peripheral master,
// and the write guard of its peripherals
// assumes the bus clock runs whenever transfers are made
//
// Contract
// R01: answer as upstream slave and turn each transfer into a peripheral access
// R02: downstream follows the peripheral protocol: waits, errors, protection
// R03: byte, half-word and word writes drive only the addressed strobes
// R04: reads carry the same lane strobes as writes
// R05: address and write data go out together in the setup cycle
// R06: the system keeps the bridge clock running while transfers are needed
// R07: one protection bit per peripheral, indexed by its slot
// R08: debugger writes ignore protection
// R09: separate clear and set addresses, no read-modify-write
// R10: writing one to a clear bit unprotects that peripheral
// R11: writing one to a set bit protects that peripheral
// R12: both guard addresses read the same protection vector
// R13: non-debug write to protected peripheral is dropped with an error
// R14: protecting an already protected peripheral returns an error
// R15: unprotecting an already unprotected peripheral returns an error
// R16: guard clock on from reset, guard runs while its clock runs
// R17: zero bits in set or clear leave protection alone, no error
// R18: peripheral or guard errors return as upstream error responses

`timescale 1ns/1ps

module abgd_bridge
    import abgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [3:0] hmaster,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,
    output logic psel,
    output logic penable,
    output logic [ADDR_W-1:0] paddr,
    output logic [SLOT_W-1:0] pslot,
    output logic pwrite,
    output logic [DATA_W-1:0] pwdata,
    output logic [3:0] pstrb,
    output logic [2:0] pprot,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);

    abgd_state_e state_r;
    abgd_state_e state_nxt;
    logic hreadyout_r;
    logic hresp_r;
    logic [DATA_W-1:0] hrdata_r;
    logic psel_r;
    logic penable_r;
    logic [ADDR_W-1:0] paddr_r;
    logic pwrite_r;
    logic [DATA_W-1:0] pwdata_r;
    logic [3:0] pstrb_r;
    logic [2:0] pprot_r;
    logic [ADDR_W-1:0] addr_r;
    logic write_r;
    logic [2:0] size_r;
    logic [3:0] prot_r;
    logic dbg_r;
    logic take;
    logic [SLOT_W-1:0] slot;
    logic guard_hit;
    logic reg_hit;
    logic guard_we;
    logic guard_err;
    logic blocked;
    logic [NPERIPH-1:0] prot_vec;

    // ------------------------------------------------------------
    // lane strobes from size and low address
    // ------------------------------------------------------------
    function automatic logic [3:0] lane_mask(input logic [2:0] sz,
                                             input logic [1:0] a);
        logic [3:0] m;
        m = 4'hf;
        if (sz == HSIZE_BYTE) begin
            m = 4'h1 << a;
        end else if (sz == HSIZE_HALF) begin
            m = a[1] ? 4'hc : 4'h3;
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // a new address phase is only seen while the bridge shows ready
    assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready &&
                  (state_r == ST_IDLE || state_r == ST_ERR2); // [R01]
    assign slot = addr_r[SLOT_LSB +: SLOT_W];
    assign guard_hit = (slot == GUARD_SLOT);
    assign reg_hit = (addr_r[9:0] == OFF_PROT_CLEAR) ||
                     (addr_r[9:0] == OFF_PROT_SET); // [R09]
    assign guard_we = (state_r == ST_DATA) && guard_hit && write_r &&
                      reg_hit;
    // debugger writes pass whatever the bit says
    assign blocked = write_r && prot_vec[slot] && !dbg_r; // [R07] [R08]

    // ------------------------------------------------------------
    // write guard, its clock is the bridge clock, live from reset
    // ------------------------------------------------------------
    abgd_guard u_guard ( // [R16]
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(ce),
        .wr_en(guard_we),
        .wr_set(addr_r[9:0] == OFF_PROT_SET),
        .wr_data(hwdata),
        .prot_vec(prot_vec),
        .wr_err(guard_err)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_DATA;
                end
            end
            ST_DATA: begin
                if (guard_hit) begin
                    // [R14] [R15]
                    state_nxt = (guard_we && guard_err) ? ST_ERR1 : ST_IDLE;
                end else if (blocked) begin
                    state_nxt = ST_ERR1; // [R13]
                end else begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                state_nxt = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (pready) begin
                    state_nxt = pslverr ? ST_ERR1 : ST_IDLE; // [R18]
                end
            end
            ST_ERR1: begin
                state_nxt = ST_ERR2;
            end
            ST_ERR2: begin
                state_nxt = take ? ST_DATA : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // captured address phase
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= '0;
            write_r <= 1'b0;
            size_r <= 3'h0;
            prot_r <= 4'h0;
            dbg_r <= 1'b0;
        end else if (ce && take) begin
            addr_r <= haddr;
            write_r <= hwrite;
            size_r <= hsize;
            prot_r <= hprot;
            dbg_r <= (hmaster == DEBUG_MASTER_ID); // [R08]
        end
    end

    // ------------------------------------------------------------
    // upstream answer: stall, two-cycle error, read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            hrdata_r <= '0;
        end else if (ce) begin
            hreadyout_r <= (state_nxt == ST_IDLE) ||
                           (state_nxt == ST_ERR2);
            // [R13] [R18]
            hresp_r <= (state_nxt == ST_ERR1) || (state_nxt == ST_ERR2);
            if (state_r == ST_DATA && guard_hit && !write_r) begin
                hrdata_r <= reg_hit ? prot_vec : '0; // [R12]
            end else if (state_r == ST_ACCESS && pready && !pslverr) begin
                hrdata_r <= prdata; // [R01]
            end
        end
    end

    // ------------------------------------------------------------
    // downstream phases
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            psel_r <= 1'b0;
            penable_r <= 1'b0;
        end else if (ce) begin
            psel_r <= (state_nxt == ST_SETUP) ||
                      (state_nxt == ST_ACCESS); // [R02]
            penable_r <= (state_nxt == ST_ACCESS); // [R02]
        end
    end

    // ------------------------------------------------------------
    // downstream address, data, strobes, protection
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            paddr_r <= '0;
            pwrite_r <= 1'b0;
            pwdata_r <= '0;
            pstrb_r <= 4'h0;
            pprot_r <= 3'h0;
        end else if (ce && state_nxt == ST_SETUP) begin
            // address and data leave in the same cycle [R05]
            paddr_r <= addr_r;
            pwrite_r <= write_r;
            pwdata_r <= hwdata;
            pstrb_r <= lane_mask(size_r, addr_r[1:0]); // [R03] [R04]
            // privileged, secure, data or instruction [R02]
            pprot_r <= {~prot_r[0], 1'b0, prot_r[1]};
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign psel = psel_r;
    assign penable = penable_r;
    assign paddr = paddr_r;
    assign pslot = paddr_r[SLOT_LSB +: SLOT_W];
    assign pwrite = pwrite_r;
    assign pwdata = pwdata_r;
    assign pstrb = pstrb_r;
    assign pprot = pprot_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n || !ce);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access_done;
        psel && penable && pready;
    endsequence
    sequence s_err_pair;
        hresp && !hreadyout ##1 hresp && hreadyout;
    endsequence

    chk_setup_access: assert property ( // [R02] [R05]
        s_setup |=> psel && penable && $stable(paddr) && $stable(pwdata))
        else $error("setup not followed by access");

    chk_access_hold: assert property ( // [R02]
        psel && penable && !pready |=> psel && penable && $stable(paddr))
        else $error("access dropped during wait");

    chk_strobe_lanes: assert property ( // [R03] [R04]
        s_setup |-> pstrb[paddr[1:0]] && $countones(pstrb) ==
            ((size_r == HSIZE_BYTE) ? 1 : (size_r == HSIZE_HALF) ? 2 : 4))
        else $error("strobes do not match size and address");

    chk_slave_err: assert property ( // [R18]
        s_access_done ##0 pslverr |=> s_err_pair)
        else $error("peripheral error not returned upstream");

    chk_read_data: assert property ( // [R01]
        s_access_done ##0 !pslverr ##0 !pwrite |=> hreadyout && !hresp
            && hrdata == $past(prdata))
        else $error("read data not returned");

    chk_write_block: assert property ( // [R13]
        state_r == ST_DATA && !guard_hit && blocked
            |=> !psel [*2] ##0 hresp)
        else $error("protected write reached peripheral");

    chk_debug_pass: assert property ( // [R08]
        state_r == ST_DATA && !guard_hit && write_r && dbg_r
            |=> s_setup)
        else $error("debugger write was blocked");

    chk_guard_err: assert property ( // [R14] [R15]
        guard_we && guard_err |=> s_err_pair)
        else $error("double protect change not flagged");

    chk_guard_read: assert property ( // [R12]
        state_r == ST_DATA && guard_hit && reg_hit && !write_r
            |=> hreadyout && hrdata == $past(prot_vec))
        else $error("guard read wrong vector");
endmodule

// ### verification/abgd_apb_slave.sv
// peripheral register model standing behind the bridge's downstream port
// assumes the bridge clock and reset; waits and errors set by the bench

`timescale 1ns/1ps

module abgd_apb_slave
    import abgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [1:0] wait_n,
    input wire logic err_en,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] seen_strb,
    output logic [2:0] seen_prot
);
    // ----------------------------------------------------------------
    // storage and access phase
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [0:15];
    logic [1:0] cnt_r;
    logic [DATA_W-1:0] last_r;
    logic [3:0] idx;

    // ready after wait_n access cycles, error only with ready
    assign idx = paddr[5:2];
    assign pready = psel && penable && (cnt_r == wait_n);
    assign pslverr = pready && err_en;
    // data bus shows junk when not answering a read
    assign prdata = (pready && !pwrite) ? mem_r[idx] : ~last_r;

    // wait count, lane-wise writes, record of strobes and protection
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 2'h0;
            last_r <= 32'h0;
            seen_strb <= 4'h0;
            seen_prot <= 3'h0;
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= 32'h0;
            end
        end else if (psel && penable && !pready) begin
            cnt_r <= cnt_r + 2'h1;
        end else begin
            cnt_r <= 2'h0;
            if (pready) begin
                seen_strb <= pstrb;
                seen_prot <= pprot;
                if (!pwrite) begin
                    last_r <= mem_r[idx];
                end else if (!err_en) begin
                    for (int k = 0; k < 4; k++) begin
                        if (pstrb[k]) begin
                            mem_r[idx][k*8 +: 8] <= pwdata[k*8 +: 8];
                        end
                    end
                end
            end
        end
    end
endmodule

// ### verification/ahb_apb_bridge_write_guard_tb_top.sv
// bench for the bridge: drives the upstream bus, checks the results
// assumes the peripheral model and the bridge share one clock

`timescale 1ns/1ps

module ahb_apb_bridge_write_guard_tb_top;
    import abgd_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic ref_clk, arst_n, hsel, hwrite, hreadyout, hresp, psel, penable;
    logic pwrite, pready, pslverr, err_en, ce;
    logic [1:0] htrans, wait_n;
    logic [2:0] hsize, pprot, seen_prot;
    logic [3:0] hmaster, pstrb, seen_strb, hprot;
    logic [4:0] pslot;
    logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, rd_v, setup_wd;
    logic rs_v;
    int n_errors = 0;
    int n_checks = 0;
    localparam logic [31:0] G_CLR = {17'h0, GUARD_SLOT, OFF_PROT_CLEAR};
    localparam logic [31:0] G_SET = {17'h0, GUARD_SLOT, OFF_PROT_SET};

    abgd_bridge i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hprot(hprot), .hmaster(hmaster), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .psel(psel), .penable(penable), .paddr(paddr),
        .pslot(pslot), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    abgd_apb_slave i_slv (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .pprot(pprot), .wait_n(wait_n), .err_en(err_en),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seen_strb(seen_strb), .seen_prot(seen_prot));

    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
    // write data as seen in the setup cycle
    always @(posedge ref_clk) begin
        if (psel && !penable && pwrite) setup_wd <= pwdata;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic acc(input logic wr, input logic [31:0] a,
        input logic [2:0] sz, input logic [31:0] wd, input logic [3:0] mid);
        int i;
        @(negedge ref_clk);
        hsel = 1'b1;
        htrans = 2'h2;
        haddr = a;
        hwrite = wr;
        hsize = sz;
        hmaster = mid;
        @(negedge ref_clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = wd;
        for (i = 0; i < 40; i++) begin
            @(negedge ref_clk);
            if (hreadyout === 1'b1) break;
        end
        rs_v = hresp;
        rd_v = hrdata;
    endtask
    task automatic chk_d(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_r(input string nm, input logic e, input logic g);
        chk_d(nm, {31'h0, e}, {31'h0, g});
    endtask
    function automatic logic [31:0] pa(input int s, input int o);
        return 32'((s << 10) + o);
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk_r("ready", 1'b1, hreadyout);
        acc(1'b0, G_CLR, 3'h2, 32'h0, 4'h0);
        chk_d("clear view", 32'h0, rd_v);
        acc(1'b0, G_SET, 3'h2, 32'h0, 4'h0);
        chk_d("set view", 32'h0, rd_v);
        $display("test reset done");
    endtask
    task automatic t_word();
        wait_n = 2'h2;
        acc(1'b1, pa(1, 8), 3'h2, 32'h1234_5678, 4'h0);
        chk_r("resp", 1'b0, rs_v);
        chk_d("mem", 32'h1234_5678, i_slv.mem_r[2]);
        chk_d("setup data", 32'h1234_5678, setup_wd);
        chk_d("strobe", 32'hf, {28'h0, seen_strb});
        chk_d("prot", 32'h1, {29'h0, seen_prot});
        chk_d("slot", 32'h1, {27'h0, pslot});
        wait_n = 2'h0;
        hprot = 4'h2;
        acc(1'b0, pa(1, 8), 3'h2, 32'h0, 4'h0);
        chk_d("read", 32'h1234_5678, rd_v);
        chk_d("rd prot", 32'h5, {29'h0, seen_prot});
        hprot = 4'h3;
        $display("test word done");
    endtask
    task automatic t_narrow();
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, pa(2, k), HSIZE_BYTE, 32'(8'ha0 + k) << (8 * k), 4'h0);
            chk_d("byte strobe", 32'(1 << k), {28'h0, seen_strb});
        end
        chk_d("bytes", 32'ha3a2_a1a0, i_slv.mem_r[0]);
        acc(1'b1, pa(2, 2), HSIZE_HALF, 32'h5566_0000, 4'h0);
        chk_d("half strobe", 32'hc, {28'h0, seen_strb});
        chk_d("half", 32'h5566_a1a0, i_slv.mem_r[0]);
        acc(1'b0, pa(2, 1), HSIZE_BYTE, 32'h0, 4'h0);
        chk_d("rd byte strobe", 32'h2, {28'h0, seen_strb});
        acc(1'b0, pa(2, 0), HSIZE_HALF, 32'h0, 4'h0);
        chk_d("rd half strobe", 32'h3, {28'h0, seen_strb});
        $display("test narrow done");
    endtask
    task automatic t_slverr();
        err_en = 1'b1;
        wait_n = 2'h1;
        acc(1'b1, pa(3, 0), 3'h2, 32'h1, 4'h0);
        chk_r("write err", 1'b1, rs_v);
        acc(1'b0, pa(3, 0), 3'h2, 32'h0, 4'h0);
        chk_r("read err", 1'b1, rs_v);
        err_en = 1'b0;
        wait_n = 2'h0;
        $display("test slave error done");
    endtask
    task automatic t_guard();
        acc(1'b1, G_SET, 3'h2, 32'h2, 4'h0);
        chk_r("set", 1'b0, rs_v);
        acc(1'b0, G_CLR, 3'h2, 32'h0, 4'h0);
        chk_d("vec", 32'h2, rd_v);
        acc(1'b1, pa(1, 8), 3'h2, 32'h0, 4'h0);
        chk_r("blocked", 1'b1, rs_v);
        chk_d("kept", 32'h1234_5678, i_slv.mem_r[2]);
        acc(1'b1, pa(1, 8), 3'h2, 32'hcafe_0001, DEBUG_MASTER_ID);
        chk_r("debug", 1'b0, rs_v);
        chk_d("debug mem", 32'hcafe_0001, i_slv.mem_r[2]);
        acc(1'b1, pa(2, 4), 3'h2, 32'h77, 4'h0);
        chk_r("other slot", 1'b0, rs_v);
        acc(1'b1, G_SET, 3'h2, 32'h6, 4'h0);
        chk_r("double set", 1'b1, rs_v);
        acc(1'b1, G_SET, 3'h2, 32'h0, 4'h0);
        chk_r("zero set", 1'b0, rs_v);
        acc(1'b0, G_SET, 3'h2, 32'h0, 4'h0);
        chk_d("vec kept", 32'h2, rd_v);
        acc(1'b1, G_CLR, 3'h2, 32'h2, 4'h0);
        chk_r("clear", 1'b0, rs_v);
        acc(1'b0, G_SET, 3'h2, 32'h0, 4'h0);
        chk_d("vec clear", 32'h0, rd_v);
        acc(1'b1, pa(1, 8), 3'h2, 32'h9, 4'h0);
        chk_d("unblocked", 32'h9, i_slv.mem_r[2]);
        acc(1'b1, G_CLR, 3'h2, 32'h2, 4'h0);
        chk_r("double clear", 1'b1, rs_v);
        acc(1'b1, G_CLR, 3'h2, 32'h0, 4'h0);
        chk_r("zero clear", 1'b0, rs_v);
        $display("test guard done");
    endtask
    task automatic t_freeze();
        ce = 1'b0;
        acc(1'b1, G_SET, 3'h2, 32'h8, 4'h0);
        ce = 1'b1;
        acc(1'b0, G_SET, 3'h2, 32'h0, 4'h0);
        chk_d("frozen vec", 32'h0, rd_v);
        $display("test freeze done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence; clock enable only dropped in the freeze test
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        hprot = 4'h3;
        {hsel, hwrite, err_en} = 3'h0;
        htrans = 2'h0;
        wait_n = 2'h0;
        hsize = 3'h2;
        hmaster = 4'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        t_reset();
        t_word();
        t_narrow();
        t_slverr();
        t_guard();
        t_freeze();
        test_done();
    end
endmodule
